/* cia_top.sv */
// block-level interrupt enable and status registers for a three-channel line unit
// assumes the serial host decoder gives one-cycle read/write strobes with address and data
`timescale 1ns/1ps
`default_nettype none
module cia_top (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire cia_pkg::cia_addr_t addr_i,
  input wire cia_pkg::cia_data_t wdata_i,
  input wire cia_pkg::cia_chmask_t src_req_i,
  output logic [`CIA_DATA_W-1:0] rdata_o,
  output logic rdata_vld_o,
  output logic [`CIA_NUM_CH-1:0] blk_en_o,
  output logic [`CIA_NUM_CH-1:0] pend_o
);
  import cia_pkg::*;
  cia_pend_if pif ();
  cia_chmask_t blk_en_q;
  cia_chmask_t src_rd;
  cia_data_t rdata_d;
  logic en_wr_hit;
  logic en_rd_hit;
  logic st_wr_hit;
  logic st_rd_hit;
  logic other_rd_hit;
  // strobe decodes shared by the checks at the bottom; the datapath keeps its own compares
  assign en_wr_hit = wr_stb_i && (addr_i == `CIA_OFF_BLK_IEN);
  assign en_rd_hit = rd_stb_i && (addr_i == `CIA_OFF_BLK_IEN);
  assign st_wr_hit = wr_stb_i && (addr_i == `CIA_OFF_BLK_ISTAT);
  assign st_rd_hit = rd_stb_i && (addr_i == `CIA_OFF_BLK_ISTAT);
  assign other_rd_hit = rd_stb_i && !en_rd_hit && !st_rd_hit;
  // only the low channel bits exist; upper written bits are simply dropped
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_en_q <= cia_chmask_t'(`CIA_RST_BLK_IEN);
    end else if (wr_stb_i && addr_i == `CIA_OFF_BLK_IEN) begin
      blk_en_q <= wdata_i[`CIA_NUM_CH-1:0];
    end
  end
  // a read of a channel's source status register clears its pending flag
  always_comb begin
    src_rd = '0;
    if (rd_stb_i) begin
      src_rd[0] = (addr_i == `CIA_OFF_SRC_ISTAT_CH0);
      src_rd[1] = (addr_i == `CIA_OFF_SRC_ISTAT_CH1);
      src_rd[2] = (addr_i == `CIA_OFF_SRC_ISTAT_CH2);
    end
  end
  assign pif.blk_en = blk_en_q;
  assign pif.src_req = src_req_i;
  assign pif.src_rd = src_rd;
  cia_chan_pend u_pend (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pif(pif)
  );
  // read mux; other addresses belong to neighbouring blocks and read zero here
  always_comb begin
    rdata_d = '0;
    case (addr_i)
      `CIA_OFF_BLK_IEN: rdata_d[`CIA_NUM_CH-1:0] = blk_en_q;
      `CIA_OFF_BLK_ISTAT: rdata_d[`CIA_NUM_CH-1:0] = pif.pend;
      default: rdata_d = '0;
    endcase
  end
  // registered read answer, one cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `CIA_RST_BLK_ISTAT;
      rdata_vld_o <= 1'b0;
    end else begin
      rdata_vld_o <= rd_stb_i;
      if (rd_stb_i) begin
        rdata_o <= rdata_d;
      end
    end
  end
  // mirrored outputs, one cycle behind the flags; writes to status are ignored
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_en_o <= '0;
      pend_o <= '0;
    end else begin
      blk_en_o <= blk_en_q;
      pend_o <= pif.pend;
    end
  end

  // status reads: upper bits zero, valid pulse along with the data
  AST_STATUS_UPPER_ZERO: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    st_rd_hit |=> rdata_o[7:3] == 5'h00 && rdata_vld_o)
    else $error("status upper bits not zero");
  // a write, one idle cycle, then a readback of the same register
  AST_ENABLE_READBACK: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    en_wr_hit ##1 !wr_stb_i ##1 en_rd_hit |=> rdata_o == {5'h00, $past(wdata_i[2:0], 3)})
    else $error("enable readback mismatch");
  // a write to the read-only status leaves the flags alone
  AST_STATUS_RO: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    st_wr_hit && src_req_i == '0 && !rd_stb_i |=> pif.pend == $past(pif.pend))
    else $error("status changed by a write");
  AST_STATUS_READS_PEND: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    st_rd_hit |=> rdata_o[2:0] == $past(pif.pend))
    else $error("status read does not match pending flags");

  // read answer timing: one valid pulse per strobe, data held between reads
  AST_VLD_AFTER_READ: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    rd_stb_i |=> rdata_vld_o)
    else $error("read strobe not answered by a valid pulse");
  AST_VLD_NEEDS_READ: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !rd_stb_i |=> !rdata_vld_o)
    else $error("valid pulse without a read strobe");
  AST_RDATA_HOLDS: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !rd_stb_i |=> $stable(rdata_o))
    else $error("read data changed without a read");

  // unused bits and addresses owned by neighbouring blocks answer zero
  AST_ENABLE_UPPER_ZERO: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    en_rd_hit |=> rdata_o[7:3] == 5'h00)
    else $error("enable upper bits not zero");
  AST_OTHER_READS_ZERO: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    other_rd_hit |=> rdata_o == 8'h00)
    else $error("foreign address did not read zero");

  // the enable register changes only through a write to its own address
  AST_ENABLE_WRITE_LANDS: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    en_wr_hit |=> blk_en_q == $past(wdata_i[2:0]))
    else $error("enable write did not land");
  AST_ENABLE_HOLDS: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !en_wr_hit |=> $stable(blk_en_q))
    else $error("enable changed without a write to it");
  AST_ENABLE_READ_LOW: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    en_rd_hit |=> rdata_o[2:0] == $past(blk_en_q))
    else $error("enable read does not match the register");

  // register reads and mirror outputs must tell the same story
  AST_ENABLE_READ_MATCHES_MIRROR: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    en_rd_hit |=> rdata_o[2:0] == blk_en_o)
    else $error("enable read and enable mirror differ");
  AST_STATUS_MIRROR_READ: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    st_rd_hit |=> rdata_o[2:0] == pend_o)
    else $error("status read and pending mirror differ");
  // reading the block status must not clear anything; only source reads do
  AST_STATUS_READ_KEEPS_FLAGS: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    st_rd_hit |=> (pif.pend & $past(pif.pend)) == $past(pif.pend))
    else $error("status read cleared a pending flag");

  // mirrors trail their sources by one cycle; a poller of these pins sees that lag
  AST_ENABLE_MIRROR: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    blk_en_o == $past(blk_en_q))
    else $error("enable mirror does not trail the register");
  AST_PEND_MIRROR: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    pend_o == $past(pif.pend))
    else $error("pending mirror does not trail the flags");

  // all outputs are quiet on the first edge after reset lets go
  AST_RESET_QUIET: assert property (@(posedge ref_clk_i)
    $rose(rst_n_i) |->
    rdata_vld_o == 1'b0 && rdata_o == 8'h00 && blk_en_o == 3'h0 && pend_o == 3'h0)
    else $error("outputs not at reset values after reset release");

  // per-channel checks, one copy per pending flag
  genvar c;
  generate
    for (c = 0; c < `CIA_NUM_CH; c++) begin : g_chk
      // a flag may only rise when its request and its block enable were both high one cycle before
      AST_CH_RISE_NEEDS_ENABLE: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        $rose(pif.pend[c]) |-> $past(src_req_i[c]) && $past(blk_en_q[c]))
        else $error("pending flag rose without an enabled request");
      // a flag may only fall after a read of its own source status register
      AST_CH_FALL_NEEDS_READ: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        $fell(pif.pend[c]) |-> $past(src_rd[c]))
        else $error("pending flag fell without its source status read");
      // the status bit of this channel reports this channel's flag
      AST_CH_STATUS_BIT: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        st_rd_hit |=> rdata_o[c] == $past(pif.pend[c]))
        else $error("status bit reports the wrong channel");
      // the enable bit of this channel reads back in its own position
      AST_CH_ENABLE_BIT: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        en_rd_hit |=> rdata_o[c] == $past(blk_en_q[c]))
        else $error("enable bit reads back in the wrong position");
      // a disabled channel with a clear flag keeps it clear
      AST_CH_MASKED_STAYS_CLEAR: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        !blk_en_q[c] && !pif.pend[c] |=> !pif.pend[c])
        else $error("disabled channel raised its flag");
      // the pending pin follows a new flag one cycle later
      AST_CH_PEND_OUT_LAGS: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        $rose(pif.pend[c]) |=> pend_o[c])
        else $error("pending pin did not follow a new flag");
    end
  endgenerate

endmodule : cia_top
`default_nettype wire

/* cia_params.svh */
// constants for the channel interrupt aggregator: channel count, widths, offsets, reset values
// assumes an 8-bit register port with 6-bit addresses from the serial host interface
`ifndef CIA_PARAMS_SVH
`define CIA_PARAMS_SVH
`define CIA_NUM_CH 3
`define CIA_ADDR_W 6
`define CIA_DATA_W 8
`define CIA_OFF_BLK_IEN 6'h20
`define CIA_OFF_BLK_ISTAT 6'h21
`define CIA_OFF_SRC_ISTAT_CH0 6'h02
`define CIA_OFF_SRC_ISTAT_CH1 6'h0a
`define CIA_OFF_SRC_ISTAT_CH2 6'h12
`define CIA_RST_BLK_IEN 8'h00
`define CIA_RST_BLK_ISTAT 8'h00
`define CIA_SRC_W 8
`endif

/* cia_pkg.sv */
// types shared by the channel interrupt aggregator files
// assumes cia_params.svh is on the include path
`default_nettype none
`include "cia_params.svh"
package cia_pkg;
  typedef logic [`CIA_ADDR_W-1:0] cia_addr_t;
  typedef logic [`CIA_DATA_W-1:0] cia_data_t;
  typedef logic [`CIA_NUM_CH-1:0] cia_chmask_t;
endpackage : cia_pkg
`default_nettype wire

/* cia_pend_if.sv */
// carrier between the register file and the per-channel pending logic
// assumes one clock domain; all members are synchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
interface cia_pend_if;
  import cia_pkg::*;
  cia_chmask_t blk_en;
  cia_chmask_t src_req;
  cia_chmask_t src_rd;
  cia_chmask_t pend;
  modport regs (output blk_en, output src_req, output src_rd, input pend);
  modport chan (input blk_en, input src_req, input src_rd, output pend);
endinterface : cia_pend_if
`default_nettype wire

/* cia_chan_pend.sv */
// per-channel sticky pending flags of the block-level status register
// assumes src_req is already qualified by source-level enables, same clock domain
`timescale 1ns/1ps
`default_nettype none
module cia_chan_pend (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  cia_pend_if.chan pif
);
  import cia_pkg::*;
  cia_chmask_t raise;
  // a source request only counts when its channel is enabled at block level
  assign raise = pif.src_req & pif.blk_en;
  genvar g;
  generate
    for (g = 0; g < `CIA_NUM_CH; g++) begin : g_ch
      logic pend_q;
      // set wins over the clearing read so a new event is never lost
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pend_q <= 1'b0;
        end else if (raise[g]) begin
          pend_q <= 1'b1;
        end else if (pif.src_rd[g]) begin
          pend_q <= 1'b0;
        end
      end
      assign pif.pend[g] = pend_q;
      AST_HOLD_UNTIL_READ: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) pend_q && !pif.src_rd[g] |=> pend_q)
        else $error("pending flag dropped without a source status read");
      AST_MASKED_NO_SET: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) !pend_q && !pif.blk_en[g] |=> !pend_q)
        else $error("pending flag set while channel disabled");
      AST_SET_ON_REQ: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) pif.src_req[g] && pif.blk_en[g] |=> pend_q)
        else $error("enabled request did not set pending flag");
      AST_CLEAR_ON_READ: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i) pif.src_rd[g] && !raise[g] |=> !pend_q)
        else $error("pending flag not cleared by source status read");
    end
  endgenerate
endmodule : cia_chan_pend
`default_nettype wire

/* cia_host_model.sv */
// host model: serial control port reduced to one-cycle register strobes
// assumes the device answers a read exactly one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module cia_host_model (
  input wire logic ref_clk_i,
  output logic wr_stb_o = 1'b0,
  output logic rd_stb_o = 1'b0,
  output cia_pkg::cia_addr_t addr_o = 6'h3f,
  output cia_pkg::cia_data_t wdata_o = 8'h00,
  input wire cia_pkg::cia_data_t rdata_i,
  input wire logic rdata_vld_i
);
  import cia_pkg::*;
  // one write; bus parked on an unmapped address after, data inverted
  task automatic wr(input cia_addr_t a, input cia_data_t d);
    wr_stb_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge ref_clk_i);
    wr_stb_o <= 1'b0;
    addr_o <= 6'h3f;
    wdata_o <= ~d;
    @(posedge ref_clk_i);
  endtask : wr
  // one read; strobe sampled at one edge, answer taken at the next edge
  task automatic rd(input cia_addr_t a, output cia_data_t d, output logic v);
    rd_stb_o <= 1'b1;
    addr_o <= a;
    @(posedge ref_clk_i);
    rd_stb_o <= 1'b0;
    addr_o <= 6'h3f;
    @(posedge ref_clk_i);
    v = rdata_vld_i;
    d = rdata_i;
  endtask : rd
  // service routine: reading the source status is what clears the flag
  task automatic service(input int ch);
    cia_data_t d;
    logic v;
    case (ch)
      0: rd(6'h02, d, v);
      1: rd(6'h0a, d, v);
      default: rd(6'h12, d, v);
    endcase
  endtask : service
endmodule : cia_host_model
`default_nettype wire

/* tb.sv */
// self-checking bench for the block-level interrupt enable and status registers
// assumes the host model drives the strobes and the bench drives channel events
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cia_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  cia_chmask_t src_req = 3'h0;
  logic wr_stb, rd_stb, vld, v;
  cia_addr_t addr;
  cia_data_t wdata, rdata, d;
  logic [2:0] blk_en, pend;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  cia_top dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wr_stb_i(wr_stb),
    .rd_stb_i(rd_stb), .addr_i(addr), .wdata_i(wdata), .src_req_i(src_req),
    .rdata_o(rdata), .rdata_vld_o(vld), .blk_en_o(blk_en), .pend_o(pend));
  cia_host_model host_u (.ref_clk_i(ref_clk_i), .wr_stb_o(wr_stb), .rd_stb_o(rd_stb),
    .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rdata_vld_i(vld));
  // 50 MHz clock
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // compare with case equality so an unknown never matches
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  // read through the host and check both the valid pulse and the data
  task automatic rchk(input string what, input cia_addr_t a, input cia_data_t exp);
    host_u.rd(a, d, v);
    chk({what, " valid"}, {7'h00, v}, 8'h01);
    chk(what, d, exp);
  endtask : rchk
  // hang guard, well above the roughly 90 cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  // main sequence: reset values, masked bits, then one channel at a time
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rchk("enable reset", 6'h20, 8'h00);
    rchk("status reset", 6'h21, 8'h00);
    host_u.wr(6'h20, 8'hff);
    rchk("enable upper", 6'h20, 8'h07);
    host_u.wr(6'h21, 8'hff);
    rchk("status write", 6'h21, 8'h00);
    rchk("unmapped", 6'h3f, 8'h00);
    for (int ch = 0; ch < 3; ch++) begin
      host_u.wr(6'h20, 8'h01 << ch);
      src_req <= 3'h7;
      @(posedge ref_clk_i);
      src_req <= 3'h0;
      repeat (8) @(posedge ref_clk_i);
      chk("enable mirror", {5'h00, blk_en}, 8'h01 << ch);
      chk("pend", {5'h00, pend}, 8'h01 << ch);
      // a write to the read-only status must not clear a standing flag
      host_u.wr(6'h21, 8'h00);
      rchk("status held", 6'h21, 8'h01 << ch);
      host_u.service(ch);
      rchk("status cleared", 6'h21, 8'h00);
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
